// ==== hw/tcci_pkg.sv ====
// Shared constants, types and helpers of the timer compare/capture block
package tcci_pkg;
  // Register byte addresses on the APB side
  localparam logic [7:0] OFS_CMPA_LO = 8'h00;
  localparam logic [7:0] OFS_CMPA_HI = 8'h04;
  localparam logic [7:0] OFS_CMPB_LO = 8'h08;
  localparam logic [7:0] OFS_CMPB_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP_LO = 8'h10;
  localparam logic [7:0] OFS_CAP_HI = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  // Shared mask / flag bit positions
  localparam int BIT_CAP = 5;
  localparam int BIT_CMPA = 4;
  localparam int BIT_CMPB = 3;
  localparam int BIT_OVF = 2;
  localparam int BIT_RSVD = 1;
  localparam logic [7:0] MASK_OWN = 8'h3C;
  localparam logic [7:0] MASK_STORED = 8'hFD;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_ACOMP = 5;
  localparam int CTRL_FORCE_A = 6;
  localparam int CTRL_FORCE_B = 7;
  // Waveform mode codes that matter here
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_MODE = 4'h0;

  typedef enum logic [1:0] {
    OVF_AT_MAX = 2'b00,
    OVF_AT_TOP = 2'b01,
    OVF_AT_BOTTOM = 2'b10
  } tcci_ovf_src_e;

  // Complete register state of the top module
  typedef struct packed {
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [7:0] temp;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] prdata;
    logic [3:0] mode;
    logic edge_rise;
    logic acomp_sel;
    logic force_a;
    logic force_b;
    logic blk;
    logic err;
  } tcci_regs_s;

  localparam tcci_regs_s REGS_RST = '{RST_WORD, RST_WORD, RST_WORD,
    RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, RST_MODE,
    1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};

  // Capture register acts as counter top in these modes
  function automatic logic cap_is_top(input logic [3:0] mode);
    cap_is_top = (mode == MODE_PFC_CAP) || (mode == MODE_PC_CAP) ||
                 (mode == MODE_CTC_CAP) || (mode == MODE_FAST_CAP);
  endfunction : cap_is_top

  // Which counter event sets the overflow flag
  function automatic tcci_ovf_src_e ovf_src(input logic [3:0] mode);
    if (mode == MODE_NORMAL || mode == MODE_CTC_CMPA ||
        mode == MODE_CTC_CAP) begin
      ovf_src = OVF_AT_MAX;
    end else if (mode == MODE_FAST8 || mode == MODE_FAST9 ||
                 mode == MODE_FAST10 || mode == MODE_FAST_CAP ||
                 mode == MODE_FAST_CMPA) begin
      ovf_src = OVF_AT_TOP;
    end else begin
      ovf_src = OVF_AT_BOTTOM;
    end
  endfunction : ovf_src
endpackage : tcci_pkg

// ==== hw/tcci_edge_sync.sv ====
// Three-stage input synchroniser with edge pulses
`timescale 1ns/1ps
module tcci_edge_sync
  import tcci_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic rise;
    logic fall;
  } tcci_sync_s;

  tcci_sync_s cur_ff;
  tcci_sync_s nxt_ff;

  // Level only moves when stages two and three agree
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.sh = {cur_ff.sh[1:0], pin};
    if (cur_ff.sh[1] == cur_ff.sh[2]) begin
      nxt_ff.lvl = cur_ff.sh[2];
    end
    nxt_ff.rise = nxt_ff.lvl & ~cur_ff.lvl;
    nxt_ff.fall = ~nxt_ff.lvl & cur_ff.lvl;
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign rise = cur_ff.rise;
  assign fall = cur_ff.fall;
endmodule : tcci_edge_sync

// ==== hw/tcci_cmp_chan.sv ====
// One compare channel: match detect and delayed flag-set pulse
`timescale 1ns/1ps
module tcci_cmp_chan
  import tcci_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [15:0] value,
  input wire logic block,
  input wire logic force_cmp,
  output logic match,
  output logic flag_set
);
  typedef struct packed {
    logic pend;
    logic set;
    logic match;
  } tcci_chan_s;

  tcci_chan_s cur_ff;
  tcci_chan_s nxt_ff;
  logic hit;

  // Real match seen on a tick; flag follows one tick later
  always_comb begin
    nxt_ff = cur_ff;
    hit = tick && (count == value) && !block; // [R22]
    if (tick) begin
      nxt_ff.pend = hit;
    end
    nxt_ff.set = tick && cur_ff.pend; // [R14] [R17]
    // Force drives the waveform match only, never the flag
    nxt_ff.match = hit || force_cmp; // [R15]
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign match = cur_ff.match;
  assign flag_set = cur_ff.set;
endmodule : tcci_cmp_chan

// ==== hw/tcci_top.sv ====
// Timer compare, capture and interrupt flag/mask block with APB slave
// Behaviour
// R1 - Compare values 16-bit, both bytes written together
// R2 - One shared high-byte latch for all
// R3 - Capture loads count on pin or comparator
// R4 - Low read copies capture high into latch
// R5 - Capture value can serve as counter top
// R6 - Capture request needs enable, global, flag
// R7 - Compare A request needs enable, global, flag
// R8 - Compare B request needs enable, global, flag
// R9 - Overflow request needs enable, global, flag
// R10 - Mask shared; bit one reads zero
// R11 - Flags share positions; bit one zero
// R12 - Capture flag on event, or top
// R13 - Capture flag cleared by ack or one
// R14 - Compare A flag one tick after match
// R15 - Force strobe never sets compare flag
// R16 - Compare A flag cleared by ack or one
// R17 - Compare B flag one tick after match
// R18 - Compare B flag cleared by ack or one
// R19 - Overflow flag source follows waveform mode
// R20 - Overflow flag cleared by ack or one
// R21 - Capture-as-top disconnects capture pin
// R22 - Counter write blocks next tick's matches
// R23 - Writing zero leaves a flag alone
`timescale 1ns/1ps
module tcci_top
  import tcci_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] TIMER_COUNT,
  input wire logic TIMER_TICK,
  input wire logic COUNT_WRITE,
  input wire logic COUNT_MAX,
  input wire logic COUNT_TOP,
  input wire logic COUNT_BOTTOM,
  input wire logic CAPTURE_PIN,
  input wire logic ACOMP_OUT,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic ACK_CAPTURE,
  input wire logic ACK_COMPARE_A,
  input wire logic ACK_COMPARE_B,
  input wire logic ACK_OVERFLOW,
  output logic [15:0] COMPARE_A_VALUE,
  output logic [15:0] COMPARE_B_VALUE,
  output logic [15:0] CAPTURE_VALUE,
  output logic CAPTURE_IS_TOP,
  output logic [3:0] WAVEFORM_MODE,
  output logic MATCH_A,
  output logic MATCH_B,
  output logic [2:0] OTHER_TIMER_ENABLES,
  output logic IRQ_CAPTURE,
  output logic IRQ_COMPARE_A,
  output logic IRQ_COMPARE_B,
  output logic IRQ_OVERFLOW
);
  tcci_regs_s cur_ff;
  tcci_regs_s nxt_ff;

  logic setup;
  logic done;
  logic wr;
  logic rd_setup;
  logic [7:0] pw8;
  logic cap_top;
  logic pin_rise;
  logic pin_fall;
  logic ac_rise;
  logic ac_fall;
  logic src_rise;
  logic src_fall;
  logic cap_evt;
  logic set_cap;
  logic set_a;
  logic set_b;
  logic set_ovf;
  logic frc_a;
  logic frc_b;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  // Address known to this slave
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFS_CMPA_LO) || (a == OFS_CMPA_HI) ||
              (a == OFS_CMPB_LO) || (a == OFS_CMPB_HI) ||
              (a == OFS_CAP_LO) || (a == OFS_CAP_HI) ||
              (a == OFS_MASK) || (a == OFS_FLAGS) ||
              (a == OFS_CTRL);
  endfunction : addr_ok

  // APB phase decode
  assign setup = PSEL && !PENABLE;
  assign done = PSEL && PENABLE;
  assign wr = done && PWRITE;
  assign rd_setup = setup && !PWRITE;
  assign pw8 = PWDATA[7:0];
  assign cap_top = cap_is_top(cur_ff.mode); // [R5]

  // Capture pin and comparator output cross in from outside
  tcci_edge_sync u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .pin(CAPTURE_PIN),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  tcci_edge_sync u_acomp_sync (
    .clk(CLK),
    .rst(RST),
    .pin(ACOMP_OUT),
    .rise(ac_rise),
    .fall(ac_fall)
  );

  // Event source and edge selection
  assign src_rise = cur_ff.acomp_sel ? ac_rise : pin_rise;
  assign src_fall = cur_ff.acomp_sel ? ac_fall : pin_fall;
  // Pin is cut off while capture serves as top
  assign cap_evt = (cur_ff.edge_rise ? src_rise : src_fall) &&
                   !cap_top; // [R21]

  // Forcing only acts in the non-PWM modes
  assign frc_a = cur_ff.force_a && (ovf_src(cur_ff.mode) == OVF_AT_MAX);
  assign frc_b = cur_ff.force_b && (ovf_src(cur_ff.mode) == OVF_AT_MAX);

  tcci_cmp_chan u_chan_a (
    .clk(CLK),
    .rst(RST),
    .tick(TIMER_TICK),
    .count(TIMER_COUNT),
    .value(cur_ff.cmp_a),
    .block(cur_ff.blk),
    .force_cmp(frc_a),
    .match(MATCH_A),
    .flag_set(set_a)
  );

  tcci_cmp_chan u_chan_b (
    .clk(CLK),
    .rst(RST),
    .tick(TIMER_TICK),
    .count(TIMER_COUNT),
    .value(cur_ff.cmp_b),
    .block(cur_ff.blk),
    .force_cmp(frc_b),
    .match(MATCH_B),
    .flag_set(set_b)
  );

  // Flag set sources
  assign set_cap = cap_top ? COUNT_TOP : cap_evt; // [R12]
  always_comb begin
    case (ovf_src(cur_ff.mode)) // [R19]
      OVF_AT_MAX: set_ovf = COUNT_MAX;
      OVF_AT_TOP: set_ovf = COUNT_TOP;
      OVF_AT_BOTTOM: set_ovf = COUNT_BOTTOM;
      default: set_ovf = 1'h0;
    endcase
  end

  // Set and clear vectors in shared bit positions
  always_comb begin
    set_vec = 8'h00;
    set_vec[BIT_CAP] = set_cap;
    set_vec[BIT_CMPA] = set_a;
    set_vec[BIT_CMPB] = set_b;
    set_vec[BIT_OVF] = set_ovf;
    clr_vec = 8'h00;
    // Only ones written clear; zeros leave flags alone
    if (wr && PADDR == OFS_FLAGS) begin
      clr_vec = pw8; // [R23]
    end
    clr_vec[BIT_CAP] = clr_vec[BIT_CAP] | ACK_CAPTURE; // [R13]
    clr_vec[BIT_CMPA] = clr_vec[BIT_CMPA] | ACK_COMPARE_A; // [R16]
    clr_vec[BIT_CMPB] = clr_vec[BIT_CMPB] | ACK_COMPARE_B; // [R18]
    clr_vec[BIT_OVF] = clr_vec[BIT_OVF] | ACK_OVERFLOW; // [R20]
  end

  // Next-state logic for registers and bus
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.force_a = 1'h0;
    nxt_ff.force_b = 1'h0;
    // Set wins over clear so no event is lost
    nxt_ff.flags = ((cur_ff.flags & ~clr_vec) | set_vec) &
                   MASK_OWN; // [R11]
    // Counter write masks matches on the next tick only
    if (COUNT_WRITE) begin
      nxt_ff.blk = 1'h1; // [R22]
    end else if (TIMER_TICK) begin
      nxt_ff.blk = 1'h0;
    end
    if (cap_evt) begin
      nxt_ff.cap = TIMER_COUNT; // [R3]
    end
    // Register writes complete in the access cycle
    if (wr) begin
      if (PADDR == OFS_CMPA_HI || PADDR == OFS_CMPB_HI ||
          PADDR == OFS_CAP_HI) begin
        nxt_ff.temp = pw8; // [R2]
      end else if (PADDR == OFS_CMPA_LO) begin
        nxt_ff.cmp_a = {cur_ff.temp, pw8}; // [R1]
      end else if (PADDR == OFS_CMPB_LO) begin
        nxt_ff.cmp_b = {cur_ff.temp, pw8}; // [R1]
      end else if (PADDR == OFS_CAP_LO) begin
        // Software sets the top value only when capture is top
        if (cap_top) begin
          nxt_ff.cap = {cur_ff.temp, pw8}; // [R5]
        end
      end else if (PADDR == OFS_MASK) begin
        nxt_ff.mask = pw8 & MASK_STORED; // [R10]
      end else if (PADDR == OFS_CTRL) begin
        nxt_ff.mode = pw8[CTRL_MODE_LSB +: 4];
        nxt_ff.edge_rise = pw8[CTRL_EDGE];
        nxt_ff.acomp_sel = pw8[CTRL_ACOMP];
        nxt_ff.force_a = pw8[CTRL_FORCE_A];
        nxt_ff.force_b = pw8[CTRL_FORCE_B];
      end
    end
    // Read data sampled in setup so it leaves a flip-flop
    if (setup) begin
      nxt_ff.err = !addr_ok(PADDR);
      nxt_ff.prdata = 8'h00;
    end
    if (rd_setup) begin
      if (PADDR == OFS_CMPA_LO) begin
        nxt_ff.prdata = cur_ff.cmp_a[7:0];
      end else if (PADDR == OFS_CMPA_HI) begin
        nxt_ff.prdata = cur_ff.cmp_a[15:8];
      end else if (PADDR == OFS_CMPB_LO) begin
        nxt_ff.prdata = cur_ff.cmp_b[7:0];
      end else if (PADDR == OFS_CMPB_HI) begin
        nxt_ff.prdata = cur_ff.cmp_b[15:8];
      end else if (PADDR == OFS_CAP_LO) begin
        nxt_ff.prdata = cur_ff.cap[7:0];
        nxt_ff.temp = cur_ff.cap[15:8]; // [R4]
      end else if (PADDR == OFS_CAP_HI) begin
        nxt_ff.prdata = cur_ff.temp; // [R4]
      end else if (PADDR == OFS_MASK) begin
        nxt_ff.prdata = cur_ff.mask;
      end else if (PADDR == OFS_FLAGS) begin
        nxt_ff.prdata = cur_ff.flags;
      end else if (PADDR == OFS_CTRL) begin
        // Force strobes always read back zero
        nxt_ff.prdata = {4'h0, cur_ff.mode} |
                        ({7'h00, cur_ff.edge_rise} << CTRL_EDGE) |
                        ({7'h00, cur_ff.acomp_sel} << CTRL_ACOMP);
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      cur_ff <= REGS_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Bus outputs: one wait-free access phase
  assign PREADY = PENABLE;
  assign PRDATA = {24'h000000, cur_ff.prdata};
  assign PSLVERR = done && cur_ff.err;

  // Values handed to the counter and waveform logic
  assign COMPARE_A_VALUE = cur_ff.cmp_a;
  assign COMPARE_B_VALUE = cur_ff.cmp_b;
  assign CAPTURE_VALUE = cur_ff.cap;
  assign CAPTURE_IS_TOP = cap_top; // [R5]
  assign WAVEFORM_MODE = cur_ff.mode;
  assign OTHER_TIMER_ENABLES = {cur_ff.mask[7:6], cur_ff.mask[0]};

  // Requests are levels; the core acks by vector fetch
  assign IRQ_CAPTURE = cur_ff.mask[BIT_CAP] && GLOBAL_IRQ_EN &&
                       cur_ff.flags[BIT_CAP]; // [R6]
  assign IRQ_COMPARE_A = cur_ff.mask[BIT_CMPA] && GLOBAL_IRQ_EN &&
                         cur_ff.flags[BIT_CMPA]; // [R7]
  assign IRQ_COMPARE_B = cur_ff.mask[BIT_CMPB] && GLOBAL_IRQ_EN &&
                         cur_ff.flags[BIT_CMPB]; // [R8]
  assign IRQ_OVERFLOW = cur_ff.mask[BIT_OVF] && GLOBAL_IRQ_EN &&
                        cur_ff.flags[BIT_OVF]; // [R9]

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_cmpa_write;
    wr && PADDR == OFS_CMPA_LO |=>
      COMPARE_A_VALUE == {$past(cur_ff.temp), $past(pw8)};
  endproperty
  a_cmpa_write: assert property (p_cmpa_write) // [R1]
    else $error("compare A not loaded from latch and low byte");

  property p_shared_latch;
    wr && (PADDR == OFS_CMPA_HI || PADDR == OFS_CMPB_HI ||
           PADDR == OFS_CAP_HI) |=> cur_ff.temp == $past(pw8);
  endproperty
  a_shared_latch: assert property (p_shared_latch) // [R2]
    else $error("high-byte write missed the shared latch");

  property p_cap_load;
    cap_evt |=> CAPTURE_VALUE == $past(TIMER_COUNT);
  endproperty
  a_cap_load: assert property (p_cap_load) // [R3]
    else $error("capture did not load the count");

  property p_cap_coherent;
    rd_setup && PADDR == OFS_CAP_LO && !cap_evt |=>
      cur_ff.temp == $past(CAPTURE_VALUE[15:8]) &&
      PRDATA[7:0] == $past(CAPTURE_VALUE[7:0]);
  endproperty
  a_cap_coherent: assert property (p_cap_coherent) // [R4]
    else $error("low read did not snapshot capture high byte");

  property p_irq_gate;
    !GLOBAL_IRQ_EN |-> !(IRQ_CAPTURE || IRQ_COMPARE_A ||
                         IRQ_COMPARE_B || IRQ_OVERFLOW);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R6] [R7] [R8] [R9]
    else $error("request raised with interrupts globally off");

  property p_rsvd_zero;
    done && !PWRITE && (PADDR == OFS_MASK || PADDR == OFS_FLAGS)
      |-> PRDATA[BIT_RSVD] == 1'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // [R10] [R11]
    else $error("reserved bit read as one");

  property p_flag_a_src;
    $rose(cur_ff.flags[BIT_CMPA]) |-> $past(set_a);
  endproperty
  a_flag_a_src: assert property (p_flag_a_src) // [R14] [R15]
    else $error("compare A flag set without delayed match");

  property p_ack_a;
    ACK_COMPARE_A && !set_a |=> !cur_ff.flags[BIT_CMPA];
  endproperty
  a_ack_a: assert property (p_ack_a) // [R16]
    else $error("compare A flag survived its acknowledge");

  property p_wr0_keeps;
    wr && PADDR == OFS_FLAGS && !pw8[BIT_OVF] && !ACK_OVERFLOW &&
      cur_ff.flags[BIT_OVF] |=> cur_ff.flags[BIT_OVF];
  endproperty
  a_wr0_keeps: assert property (p_wr0_keeps) // [R23] [R20]
    else $error("writing zero cleared the overflow flag");

  property p_top_nocap;
    cap_top && !(wr && PADDR == OFS_CAP_LO) |=> $stable(CAPTURE_VALUE);
  endproperty
  a_top_nocap: assert property (p_top_nocap) // [R21]
    else $error("capture loaded while capture is top");

  property p_block;
    cur_ff.blk && TIMER_TICK && !frc_a |=> !MATCH_A ##1 !set_a[*2];
  endproperty
  a_block: assert property (p_block) // [R22]
    else $error("match not blocked after counter write");

  property p_ovf_max;
    ovf_src(cur_ff.mode) == OVF_AT_MAX && COUNT_MAX |=>
      cur_ff.flags[BIT_OVF];
  endproperty
  a_ovf_max: assert property (p_ovf_max) // [R19]
    else $error("overflow flag missed in normal or CLEAR_ON_MATCH_MODE mode");

  c_capture: cover property (cap_evt ##1 IRQ_CAPTURE);
  c_match_a: cover property (set_a ##1 IRQ_COMPARE_A);
  c_ovf_ack: cover property (IRQ_OVERFLOW ##1 ACK_OVERFLOW);
endmodule : tcci_top

// ==== bench/tcci_cnt_model.sv ====
// Behavioural timer counter feeding the compare/capture block
`timescale 1ns/1ps
module tcci_cnt_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] count,
  output logic tick,
  output logic cnt_max,
  output logic cnt_top,
  output logic cnt_bottom
);
  // Tick on every second clock, so one timer clock spans two cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= run & ~tick;
      // CPU write wins over counting
      if (load)
        count <= load_val;
      else if (tick)
        count <= count + 16'h0001;
    end
  end
  // Event pulses ride on the tick that leaves the extreme value
  assign cnt_max = tick & (count == 16'hFFFF);
  assign cnt_top = cnt_max;
  assign cnt_bottom = tick & (count == 16'h0000);
endmodule : tcci_cnt_model

// ==== bench/tb_tcci_top.sv ====
// Self-checking bench for the timer compare/capture block
`timescale 1ns/1ps
module tb_tcci_top;
  import tcci_pkg::*;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, err, run = 0, load = 0, pin = 0, gie = 0;
  logic acmp = 0, tick, cmax, ctop, cbot, cistop, ma, mb;
  logic [15:0] lval = 16'h0, cnt, cmpa, cmpb, capv;
  logic [3:0] ack = 4'h0, wmode, irq;
  logic [2:0] oth;
  int fail_count = 0, n_compared = 0, seed = 50436;
  int eflags = 0, emask = 0, ea, eb, ec; // reference state

  initial begin
    forever #12.5 CLK = ~CLK;
  end

  tcci_cnt_model cnt_u (.clk(CLK), .rst(RST), .run(run), .load(load),
    .load_val(lval), .count(cnt), .tick(tick), .cnt_max(cmax),
    .cnt_top(ctop), .cnt_bottom(cbot));

  tcci_top dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_COUNT(cnt),
    .TIMER_TICK(tick), .COUNT_WRITE(load), .COUNT_MAX(cmax),
    .COUNT_TOP(ctop), .COUNT_BOTTOM(cbot), .CAPTURE_PIN(pin),
    .ACOMP_OUT(acmp), .GLOBAL_IRQ_EN(gie), .ACK_CAPTURE(ack[3]),
    .ACK_COMPARE_A(ack[2]), .ACK_COMPARE_B(ack[1]),
    .ACK_OVERFLOW(ack[0]), .COMPARE_A_VALUE(cmpa),
    .COMPARE_B_VALUE(cmpb), .CAPTURE_VALUE(capv),
    .CAPTURE_IS_TOP(cistop), .WAVEFORM_MODE(wmode), .MATCH_A(ma),
    .MATCH_B(mb), .OTHER_TIMER_ENABLES(oth), .IRQ_CAPTURE(irq[3]),
    .IRQ_COMPARE_A(irq[2]), .IRQ_COMPARE_B(irq[1]),
    .IRQ_OVERFLOW(irq[0]));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; held until PREADY is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // One more edge so callers see the settled register state
    @(posedge CLK);
  endtask : apb

  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 32'(d & 8'hFF));
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(rd, 32'(e));
    chk(32'(err), 32'h0);
  endtask : rdchk

  // High byte first into the shared latch, then the low byte
  task automatic wr16(input logic [7:0] lo, input int v);
    wr(lo + 8'h04, v >> 8);
    wr(lo, v);
  endtask : wr16

  task automatic waitn(input int n);
    repeat (n) @(posedge CLK);
  endtask : waitn

  task automatic ld(input int v);
    lval <= 16'(v);
    load <= 1'b1;
    @(posedge CLK);
    load <= 1'b0;
  endtask : ld

  task automatic pulse_ack(input int b);
    ack <= 4'(1 << b);
    @(posedge CLK);
    ack <= 4'h0;
    waitn(2);
  endtask : pulse_ack

  // Flag register and request lines against the reference state
  task automatic chkflags;
    int e;
    rdchk(OFS_FLAGS, eflags);
    e = eflags & emask & (gie ? 8'hFF : 8'h00);
    chk(32'(irq), 32'({e[5], e[4], e[3], e[2]}));
  endtask : chkflags

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Cuts a hang short well past the expected run length
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    waitn(6);
    RST <= 1'b0;
    // Reset values, then mask bit 1 stays zero
    rdchk(OFS_MASK, 0);
    rdchk(OFS_CMPA_LO, 0);
    chkflags();
    wr(OFS_MASK, 8'hFF);
    rdchk(OFS_MASK, 8'hFD);
    chk(32'(oth), 32'h7);
    emask = 8'h3C;
    wr(OFS_MASK, emask);
    gie <= 1'b1;
    $display("test reset_mask done");
    // Latch shared: a later high write of B wins for A
    ea = ($random(seed) & 16'h7F00) | 16'h0080;
    eb = ea + 2;
    wr(OFS_CMPA_HI, ea >> 8);
    wr(OFS_CMPB_HI, (ea >> 8) ^ 8'h5A);
    wr(OFS_CMPA_LO, ea);
    chk(32'(cmpa), 32'(ea ^ 16'h5A00));
    wr16(OFS_CMPA_LO, ea);
    wr16(OFS_CMPB_LO, eb);
    chk(32'(cmpa), 32'(ea));
    chk(32'(cmpb), 32'(eb));
    rdchk(OFS_CMPB_HI, eb >> 8);
    $display("test latch done");
    // Both channels match while counting up
    ld(ea - 6);
    run <= 1'b1;
    waitn(26);
    run <= 1'b0;
    eflags = 8'h18;
    chkflags();
    wr(OFS_FLAGS, 8'h00);
    chkflags();
    pulse_ack(2);
    eflags = 8'h08;
    chkflags();
    gie <= 1'b0;
    waitn(1);
    chkflags();
    gie <= 1'b1;
    wr(OFS_FLAGS, 8'h08);
    eflags = 0;
    chkflags();
    $display("test compare done");
    // Force strobes and a counter write landing on the match value
    wr(OFS_CTRL, 8'hC0);
    waitn(1);
    chk(32'({ma, mb}), 32'h3);
    waitn(5);
    chkflags();
    run <= 1'b1;
    ld(ea);
    waitn(1);
    run <= 1'b0;
    waitn(8);
    chkflags();
    $display("test force_block done");
    // Overflow in normal mode
    ld(16'hFFFE);
    run <= 1'b1;
    waitn(8);
    run <= 1'b0;
    eflags = 8'h04;
    chkflags();
    wr(OFS_FLAGS, 8'h18);
    chkflags();
    wr(OFS_FLAGS, 8'h04);
    eflags = 0;
    chkflags();
    // Phase-correct mode: flag from bottom, max never reached
    wr(OFS_CTRL, 8'h01);
    ld(16'h0000);
    run <= 1'b1;
    waitn(6);
    run <= 1'b0;
    eflags = 8'h04;
    chkflags();
    pulse_ack(0);
    eflags = 0;
    chkflags();
    $display("test overflow done");
    // Rising-edge capture of a frozen count, coherent byte reads
    wr(OFS_CTRL, 8'h10);
    ec = $random(seed) & 16'hFFFF;
    ld(ec);
    pin <= 1'b1;
    waitn(8);
    chk(32'(capv), 32'(ec));
    eflags = 8'h20;
    chkflags();
    rdchk(OFS_CAP_LO, ec & 8'hFF);
    rdchk(OFS_CAP_HI, ec >> 8);
    pin <= 1'b0;
    pulse_ack(3);
    eflags = 0;
    chkflags();
    $display("test capture done");
    // Comparator output as capture source, flag cleared by a one
    wr(OFS_CTRL, 8'h30);
    ec = ec ^ 16'h5A5A;
    ld(ec);
    acmp <= 1'b1;
    waitn(8);
    chk(32'(capv), 32'(ec));
    eflags = 8'h20;
    chkflags();
    wr(OFS_FLAGS, 8'h20);
    eflags = 0;
    chkflags();
    $display("test comparator done");
    // Capture value as top: pin ignored, flag from top event
    wr(OFS_CTRL, 8'h1C);
    chk(32'({cistop, wmode}), 32'h1C);
    wr16(OFS_CAP_LO, ea);
    chk(32'(capv), 32'(ea));
    pin <= 1'b1;
    waitn(8);
    chk(32'(capv), 32'(ea));
    chkflags();
    ld(16'hFFFE);
    run <= 1'b1;
    waitn(8);
    run <= 1'b0;
    eflags = 8'h24;
    chkflags();
    $display("test capture_top done");
    // Unmapped address answers with an error and zero data
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : tb_tcci_top
